// file: src/rtf_pkg.sv
package rtf_pkg;

  // Tag frame layout
  localparam int         FRAME_BITS   = 153;
  localparam int         HDR_MSB      = 152;
  localparam int         HDR_LSB      = 143;
  localparam logic [9:0] HDR_PATTERN  = 10'h3FE;
  localparam int         DATA_BYTES   = 14;
  localparam int         FRAME_BYTES  = 16;
  localparam int         NUM_BLOCKS   = 32;

  // Time stamp weight and clock period
  localparam int TS_LSB_PS       = 819200000;
  localparam int CLK_PERIOD_PS   = 20000;
  localparam int TS_TICK_CYCLES  = TS_LSB_PS / CLK_PERIOD_PS;
  localparam logic [15:0] TS_RESET = 16'h0000;

  // Message characters
  localparam logic [7:0] CH_SYNC   = 8'h40;
  localparam logic [7:0] CH_CR     = 8'h0D;
  localparam logic [7:0] CH_LF     = 8'h0A;
  localparam logic [7:0] CH_T      = 8'h54;
  localparam logic [7:0] CH_I      = 8'h49;
  localparam logic [7:0] CH_COMMA  = 8'h2C;
  localparam logic [7:0] CH_COLON  = 8'h3A;
  localparam logic [7:0] CH_X      = 8'h58;
  localparam logic [7:0] CH_R      = 8'h52;
  localparam logic [7:0] CH_O      = 8'h4F;
  localparam logic [7:0] CH_ZERO   = 8'h30;
  localparam logic [7:0] CH_ALPHA  = 8'h37;

  // Command characters
  localparam logic [7:0] CMD_DECODED = 8'h32;
  localparam logic [7:0] CMD_RAW     = 8'h33;
  localparam logic [7:0] CMD_VREAD   = 8'h34;
  localparam logic [7:0] CMD_WRITE   = 8'h35;
  localparam logic [7:0] CMD_FAST    = 8'h36;

  // Nibble counts of hex fields
  localparam logic [5:0] NIB_BYTE = 6'h02;
  localparam logic [5:0] NIB_TS   = 6'h04;
  localparam logic [5:0] NIB_BLK  = 6'h08;
  localparam logic [5:0] NIB_FR6  = 6'h0C;
  localparam logic [5:0] NIB_FR8  = 6'h10;
  localparam logic [5:0] NIB_FR12 = 6'h18;
  localparam logic [5:0] NIB_DEC  = 6'h1C;
  localparam logic [5:0] NIB_RAW  = 6'h24;

  // Block numbers and fast-read fields
  localparam logic [4:0] BLK_FIRST = 5'h00;
  localparam logic [4:0] BLK_LAST  = 5'h1F;
  localparam int         BLK_ID    = 1;
  localparam int         BLK_FRF0  = 3;
  localparam int         DF_LSB    = 3;

  // Block status codes from the front end
  localparam logic [1:0] BST_OK  = 2'h0;
  localparam logic [1:0] BST_BAD = 2'h1;
  localparam logic [1:0] BST_RO  = 2'h2;

  typedef enum logic [2:0] {
    RTF_K_DECODED = 3'b000,
    RTF_K_RAW     = 3'b001,
    RTF_K_VREAD   = 3'b010,
    RTF_K_WRITE   = 3'b011,
    RTF_K_FAST    = 3'b100
  } rtf_kind_t;

  typedef enum logic [3:0] {
    S_IDLE    = 4'b0000,
    S_CHECK   = 4'b0001,
    S_SYNC    = 4'b0010,
    S_CMD     = 4'b0011,
    S_NEXT    = 4'b0100,
    S_LIT     = 4'b0101,
    S_HEX     = 4'b0110,
    S_CSUM_HI = 4'b0111,
    S_CSUM_LO = 4'b1000,
    S_CR      = 4'b1001,
    S_LF      = 4'b1010
  } rtf_state_t;

endpackage

// file: src/rtf_formatter.sv
`timescale 1ns/10ps
module rtf_formatter #(
  parameter int TS_TICK_CYCLES = rtf_pkg::TS_TICK_CYCLES
) (
  // Clock, reset, enable
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic              clk_en,
  // Message request
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire rtf_pkg::rtf_kind_t req_kind,
  input  wire logic [152:0]      req_frame,
  input  wire logic [7:0]        req_tag_count_param,
  input  wire logic [4:0]        req_blk_first,
  input  wire logic [4:0]        req_blk_last,
  output logic                   frame_err,
  // Block store fill
  input  wire logic              blk_wr_en,
  input  wire logic [4:0]        blk_wr_addr,
  input  wire logic [31:0]       blk_wr_data,
  input  wire logic [1:0]        blk_wr_status,
  // Host character stream
  output logic                   tx_valid,
  input  wire logic              tx_ready,
  output logic [7:0]             tx_data,
  output logic                   tx_last
);

  localparam int DIV_W = $clog2(TS_TICK_CYCLES + 1);
  localparam logic [DIV_W-1:0] DIV_END = DIV_W'(TS_TICK_CYCLES - 1);

  function automatic logic [7:0] hex_char(input logic [3:0] nib);
    if (nib < 4'hA) begin
      hex_char = rtf_pkg::CH_ZERO + {4'h0, nib};
    end else begin
      hex_char = rtf_pkg::CH_ALPHA + {4'h0, nib};
    end
  endfunction

  function automatic logic [31:0] rev32(input logic [31:0] w);
    for (int i = 0; i < 32; i++) begin
      rev32[i] = w[31 - i];
    end
  endfunction

  // Time stamp
  logic [DIV_W-1:0] ts_div_r;
  logic [DIV_W-1:0] ts_div_nxt;
  logic [15:0]      ts_r;
  logic [15:0]      ts_nxt;

  always_comb begin
    ts_div_nxt = ts_div_r + DIV_W'(1);
    ts_nxt     = ts_r;
    if (ts_div_r == DIV_END) begin
      ts_div_nxt = '0;
      ts_nxt     = ts_r + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ts_div_r <= '0;
      ts_r     <= rtf_pkg::TS_RESET;
    end else if (clk_en) begin
      ts_div_r <= ts_div_nxt;
      ts_r     <= ts_nxt;
    end
  end

  // Block store
  logic [31:0] blk_mem [rtf_pkg::NUM_BLOCKS];
  logic [1:0]  blk_st  [rtf_pkg::NUM_BLOCKS];

  always_ff @(posedge sys_clk) begin
    if (clk_en && blk_wr_en) begin
      blk_mem[blk_wr_addr] <= blk_wr_data;
      blk_st[blk_wr_addr]  <= blk_wr_status;
    end
  end

  // Sequencer state
  rtf_pkg::rtf_state_t state_r;
  rtf_pkg::rtf_state_t state_nxt;
  rtf_pkg::rtf_kind_t  kind_r;
  rtf_pkg::rtf_kind_t  kind_nxt;
  logic [152:0]        frame_r;
  logic [152:0]        frame_nxt;
  logic [15:0]         ts_cap_r;
  logic [15:0]         ts_cap_nxt;
  logic [7:0]          tcp_r;
  logic [7:0]          tcp_nxt;
  logic [3:0]          seg_r;
  logic [3:0]          seg_nxt;
  logic [4:0]          blk_r;
  logic [4:0]          blk_nxt;
  logic [4:0]          last_r;
  logic [4:0]          last_nxt;
  logic [143:0]        hex_sr_r;
  logic [143:0]        hex_sr_nxt;
  logic [5:0]          hex_cnt_r;
  logic [5:0]          hex_cnt_nxt;
  logic [31:0]         lit_sr_r;
  logic [31:0]         lit_sr_nxt;
  logic [2:0]          lit_cnt_r;
  logic [2:0]          lit_cnt_nxt;
  logic [7:0]          sum_r;
  logic [7:0]          sum_nxt;
  logic                err_r;
  logic                err_nxt;

  // Frame unpacking
  logic [7:0]   fbyte [rtf_pkg::FRAME_BYTES];
  logic [14:0]  spacer;
  logic [111:0] dec_data;
  logic [15:0]  data_sum;
  logic         frame_ok;

  for (genvar k = 0; k < rtf_pkg::FRAME_BYTES; k++) begin : g_byte
    assign fbyte[k] = frame_r[142 - 9 * k -: 8];
  end
  for (genvar k = 0; k < rtf_pkg::FRAME_BYTES - 1; k++) begin : g_spacer
    assign spacer[k] = frame_r[134 - 9 * k];
  end
  for (genvar k = 0; k < rtf_pkg::DATA_BYTES; k++) begin : g_data
    assign dec_data[111 - 8 * k -: 8] = fbyte[k];
  end

  always_comb begin
    data_sum = 16'h0000;
    for (int i = 0; i < rtf_pkg::DATA_BYTES; i++) begin
      data_sum = data_sum + {8'h00, fbyte[i]};
    end
  end

  assign frame_ok = (frame_r[rtf_pkg::HDR_MSB:rtf_pkg::HDR_LSB] == rtf_pkg::HDR_PATTERN)
                  && (spacer == 15'h0000)
                  && (data_sum == {fbyte[14], fbyte[15]});

  // Character generator
  logic [7:0] gen_char;
  logic       gen_hex;
  logic       gen_last;
  logic       gen_valid;
  logic       load;
  logic       adv;
  logic [7:0] csum;
  logic [5:0] frf_nib;
  logic       blk_kind;

  assign csum     = 8'h00 - sum_r;
  assign blk_kind = (kind_r == rtf_pkg::RTF_K_VREAD) || (kind_r == rtf_pkg::RTF_K_WRITE);

  always_comb begin
    unique case (tcp_r[rtf_pkg::DF_LSB +: 2])
      2'h0: frf_nib = rtf_pkg::NIB_BLK;
      2'h1: frf_nib = rtf_pkg::NIB_FR6;
      2'h2: frf_nib = rtf_pkg::NIB_FR8;
      2'h3: frf_nib = rtf_pkg::NIB_FR12;
    endcase
  end

  always_comb begin
    gen_char  = rtf_pkg::CH_SYNC;
    gen_hex   = 1'b0;
    gen_last  = 1'b0;
    gen_valid = 1'b1;
    unique case (state_r)
      rtf_pkg::S_SYNC: gen_char = rtf_pkg::CH_SYNC;
      rtf_pkg::S_CMD: begin
        unique case (kind_r)
          rtf_pkg::RTF_K_DECODED: gen_char = rtf_pkg::CMD_DECODED;
          rtf_pkg::RTF_K_RAW:     gen_char = rtf_pkg::CMD_RAW;
          rtf_pkg::RTF_K_VREAD:   gen_char = rtf_pkg::CMD_VREAD;
          rtf_pkg::RTF_K_WRITE:   gen_char = rtf_pkg::CMD_WRITE;
          default:                gen_char = rtf_pkg::CMD_FAST;
        endcase
      end
      rtf_pkg::S_LIT: gen_char = lit_sr_r[31:24];
      rtf_pkg::S_HEX: begin
        gen_char = hex_char(hex_sr_r[143:140]);
        gen_hex  = 1'b1;
      end
      rtf_pkg::S_CSUM_HI: begin
        gen_char = hex_char(csum[7:4]);
        gen_hex  = 1'b1;
      end
      rtf_pkg::S_CSUM_LO: begin
        gen_char = hex_char(csum[3:0]);
        gen_hex  = 1'b1;
      end
      rtf_pkg::S_CR: gen_char = rtf_pkg::CH_CR;
      rtf_pkg::S_LF: begin
        gen_char = rtf_pkg::CH_LF;
        gen_last = 1'b1;
      end
      default: gen_valid = 1'b0;
    endcase
  end

  // Output register
  logic       out_valid_r;
  logic       out_valid_nxt;
  logic [7:0] out_char_r;
  logic [7:0] out_char_nxt;
  logic       out_hex_r;
  logic       out_hex_nxt;
  logic       out_last_r;
  logic       out_last_nxt;

  assign load = !out_valid_r || tx_ready;
  assign adv  = gen_valid && load;

  always_comb begin
    out_valid_nxt = out_valid_r;
    out_char_nxt  = out_char_r;
    out_hex_nxt   = out_hex_r;
    out_last_nxt  = out_last_r;
    if (load) begin
      out_valid_nxt = gen_valid;
      out_char_nxt  = gen_char;
      out_hex_nxt   = gen_hex;
      out_last_nxt  = gen_last;
    end
  end

  always_comb begin
    state_nxt   = state_r;
    kind_nxt    = kind_r;
    frame_nxt   = frame_r;
    ts_cap_nxt  = ts_cap_r;
    tcp_nxt     = tcp_r;
    seg_nxt     = seg_r;
    blk_nxt     = blk_r;
    last_nxt    = last_r;
    hex_sr_nxt  = hex_sr_r;
    hex_cnt_nxt = hex_cnt_r;
    lit_sr_nxt  = lit_sr_r;
    lit_cnt_nxt = lit_cnt_r;
    sum_nxt     = sum_r;
    err_nxt     = 1'b0;
    // Sum stops after the body so checksum, CR and LF leave it alone
    if (adv && state_r == rtf_pkg::S_SYNC) begin
      sum_nxt = gen_char;
    end else if (adv && state_r inside {rtf_pkg::S_CMD, rtf_pkg::S_LIT, rtf_pkg::S_HEX}) begin
      sum_nxt = sum_r + gen_char;
    end
    unique case (state_r)
      rtf_pkg::S_IDLE: begin
        if (req_valid) begin
          kind_nxt   = req_kind;
          frame_nxt  = req_frame;
          ts_cap_nxt = ts_r;
          tcp_nxt    = req_tag_count_param;
          seg_nxt    = 4'h0;
          blk_nxt    = rtf_pkg::BLK_FIRST;
          last_nxt   = rtf_pkg::BLK_LAST;
          if (req_kind == rtf_pkg::RTF_K_WRITE) begin
            blk_nxt  = req_blk_first;
            last_nxt = req_blk_last;
          end
          state_nxt = (req_kind == rtf_pkg::RTF_K_DECODED || req_kind == rtf_pkg::RTF_K_RAW)
                    ? rtf_pkg::S_CHECK : rtf_pkg::S_SYNC;
        end
      end
      rtf_pkg::S_CHECK: begin
        if (frame_ok) begin
          state_nxt = rtf_pkg::S_SYNC;
        end else begin
          state_nxt = rtf_pkg::S_IDLE;
          err_nxt   = 1'b1;
        end
      end
      rtf_pkg::S_SYNC: if (adv) state_nxt = rtf_pkg::S_CMD;
      rtf_pkg::S_CMD: if (adv) state_nxt = rtf_pkg::S_NEXT;
      rtf_pkg::S_LIT: begin
        if (adv) begin
          lit_sr_nxt  = {lit_sr_r[23:0], 8'h00};
          lit_cnt_nxt = lit_cnt_r - 3'h1;
          if (lit_cnt_r == 3'h1) state_nxt = rtf_pkg::S_NEXT;
        end
      end
      rtf_pkg::S_HEX: begin
        if (adv) begin
          hex_sr_nxt  = {hex_sr_r[139:0], 4'h0};
          hex_cnt_nxt = hex_cnt_r - 6'h01;
          if (hex_cnt_r == 6'h01) state_nxt = rtf_pkg::S_NEXT;
        end
      end
      rtf_pkg::S_NEXT: begin
        seg_nxt     = seg_r + 4'h1;
        state_nxt   = rtf_pkg::S_LIT;
        lit_cnt_nxt = 3'h1;
        if (blk_kind) begin
          unique case (seg_r)
            4'h0: lit_sr_nxt = {rtf_pkg::CH_I, 24'h000000};
            4'h1: begin
              state_nxt   = rtf_pkg::S_HEX;
              hex_sr_nxt  = {rev32(blk_mem[rtf_pkg::BLK_ID]), 112'h0};
              hex_cnt_nxt = rtf_pkg::NIB_BLK;
            end
            4'h2: begin
              lit_sr_nxt  = {rtf_pkg::CH_COMMA,
                             hex_char({3'h0, blk_r[4]}), hex_char(blk_r[3:0]),
                             rtf_pkg::CH_COLON};
              lit_cnt_nxt = 3'h4;
            end
            4'h3: begin
              if (blk_st[blk_r] == rtf_pkg::BST_BAD) begin
                lit_sr_nxt  = {4{rtf_pkg::CH_X}};
                lit_cnt_nxt = 3'h4;
              end else if (kind_r == rtf_pkg::RTF_K_WRITE && blk_st[blk_r] == rtf_pkg::BST_RO) begin
                lit_sr_nxt  = {rtf_pkg::CH_R, rtf_pkg::CH_O, 16'h0000};
                lit_cnt_nxt = 3'h2;
              end else begin
                state_nxt   = rtf_pkg::S_HEX;
                hex_sr_nxt  = {rev32(blk_mem[blk_r]), 112'h0};
                hex_cnt_nxt = rtf_pkg::NIB_BLK;
              end
            end
            default: begin
              if (blk_r == last_r) begin
                state_nxt = rtf_pkg::S_CSUM_HI;
              end else begin
                state_nxt = rtf_pkg::S_NEXT;
                blk_nxt   = blk_r + 5'h01;
                seg_nxt   = 4'h2;
              end
            end
          endcase
        end else begin
          unique case (seg_r)
            4'h0: lit_sr_nxt = {rtf_pkg::CH_T, 24'h000000};
            4'h1: begin
              state_nxt   = rtf_pkg::S_HEX;
              hex_sr_nxt  = {ts_cap_r, 128'h0};
              hex_cnt_nxt = rtf_pkg::NIB_TS;
            end
            4'h2, 4'h4, 4'h6: begin
              lit_sr_nxt = {rtf_pkg::CH_COMMA, 24'h000000};
              if (seg_r == 4'h4 && kind_r != rtf_pkg::RTF_K_FAST) begin
                state_nxt = rtf_pkg::S_CSUM_HI;
              end
            end
            4'h3: begin
              state_nxt = rtf_pkg::S_HEX;
              if (kind_r == rtf_pkg::RTF_K_DECODED) begin
                hex_sr_nxt  = {dec_data, 32'h0};
                hex_cnt_nxt = rtf_pkg::NIB_DEC;
              end else if (kind_r == rtf_pkg::RTF_K_RAW) begin
                hex_sr_nxt  = {frame_r[142:0], 1'b0};
                hex_cnt_nxt = rtf_pkg::NIB_RAW;
              end else begin
                hex_sr_nxt  = {tcp_r, 136'h0};
                hex_cnt_nxt = rtf_pkg::NIB_BYTE;
              end
            end
            4'h5: begin
              state_nxt   = rtf_pkg::S_HEX;
              hex_sr_nxt  = {rev32(blk_mem[rtf_pkg::BLK_ID]), 112'h0};
              hex_cnt_nxt = rtf_pkg::NIB_BLK;
            end
            4'h7: begin
              state_nxt   = rtf_pkg::S_HEX;
              hex_sr_nxt  = {rev32(blk_mem[rtf_pkg::BLK_FRF0]),
                             rev32(blk_mem[rtf_pkg::BLK_FRF0 + 1]),
                             rev32(blk_mem[rtf_pkg::BLK_FRF0 + 2]), 48'h0};
              hex_cnt_nxt = frf_nib;
            end
            default: state_nxt = rtf_pkg::S_CSUM_HI;
          endcase
        end
      end
      rtf_pkg::S_CSUM_HI: if (adv) state_nxt = rtf_pkg::S_CSUM_LO;
      rtf_pkg::S_CSUM_LO: if (adv) state_nxt = rtf_pkg::S_CR;
      rtf_pkg::S_CR: if (adv) state_nxt = rtf_pkg::S_LF;
      rtf_pkg::S_LF: if (adv) state_nxt = rtf_pkg::S_IDLE;
      default: state_nxt = rtf_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r     <= rtf_pkg::S_IDLE;
      kind_r      <= rtf_pkg::RTF_K_DECODED;
      frame_r     <= '0;
      ts_cap_r    <= rtf_pkg::TS_RESET;
      tcp_r       <= 8'h00;
      seg_r       <= 4'h0;
      blk_r       <= rtf_pkg::BLK_FIRST;
      last_r      <= rtf_pkg::BLK_LAST;
      hex_sr_r    <= '0;
      hex_cnt_r   <= 6'h00;
      lit_sr_r    <= 32'h00000000;
      lit_cnt_r   <= 3'h0;
      sum_r       <= 8'h00;
      err_r       <= 1'b0;
      out_valid_r <= 1'b0;
      out_char_r  <= 8'h00;
      out_hex_r   <= 1'b0;
      out_last_r  <= 1'b0;
    end else if (clk_en) begin
      state_r     <= state_nxt;
      kind_r      <= kind_nxt;
      frame_r     <= frame_nxt;
      ts_cap_r    <= ts_cap_nxt;
      tcp_r       <= tcp_nxt;
      seg_r       <= seg_nxt;
      blk_r       <= blk_nxt;
      last_r      <= last_nxt;
      hex_sr_r    <= hex_sr_nxt;
      hex_cnt_r   <= hex_cnt_nxt;
      lit_sr_r    <= lit_sr_nxt;
      lit_cnt_r   <= lit_cnt_nxt;
      sum_r       <= sum_nxt;
      err_r       <= err_nxt;
      out_valid_r <= out_valid_nxt;
      out_char_r  <= out_char_nxt;
      out_hex_r   <= out_hex_nxt;
      out_last_r  <= out_last_nxt;
    end
  end

  assign req_ready = (state_r == rtf_pkg::S_IDLE);
  assign frame_err = err_r;
  assign tx_valid  = out_valid_r;
  assign tx_data   = out_char_r;
  assign tx_last   = out_valid_r && out_last_r;

  property p_reject_bad;
    @(posedge sys_clk) disable iff (reset)
      (clk_en && state_r == rtf_pkg::S_CHECK && !frame_ok)
      |=> (state_r == rtf_pkg::S_IDLE && frame_err && !tx_valid);
  endproperty
  a_reject_bad: assert property (p_reject_bad) else $error("bad frame not dropped");

  property p_good_sent;
    @(posedge sys_clk) disable iff (reset)
      (clk_en && state_r == rtf_pkg::S_CHECK && frame_ok) |=> state_r == rtf_pkg::S_SYNC;
  endproperty
  a_good_sent: assert property (p_good_sent) else $error("good frame not sent");

  property p_ts_tick;
    @(posedge sys_clk) disable iff (reset)
      (clk_en && ts_div_r == DIV_END) |=> ts_r == $past(ts_r) + 16'h0001;
  endproperty
  a_ts_tick: assert property (p_ts_tick) else $error("time stamp missed tick");

  property p_sync_first;
    @(posedge sys_clk) disable iff (reset)
      (clk_en && state_r == rtf_pkg::S_IDLE && req_valid)
      |-> ##[1:4] (state_r == rtf_pkg::S_SYNC || state_r == rtf_pkg::S_IDLE);
  endproperty
  a_sync_first: assert property (p_sync_first) else $error("sync not reached");

  property p_cr_lf;
    @(posedge sys_clk) disable iff (reset)
      (clk_en && tx_valid && tx_ready && tx_data == rtf_pkg::CH_CR && !out_hex_r)
      |=> (tx_valid && tx_data == rtf_pkg::CH_LF && tx_last);
  endproperty
  a_cr_lf: assert property (p_cr_lf) else $error("LF does not follow CR");

  property p_hold;
    @(posedge sys_clk) disable iff (reset)
      (clk_en && tx_valid && !tx_ready) |=> (tx_valid && $stable(tx_data));
  endproperty
  a_hold: assert property (p_hold) else $error("character lost under stall");

  property p_hex_digit;
    @(posedge sys_clk) disable iff (reset)
      (tx_valid && out_hex_r) |-> ((tx_data >= 8'h30 && tx_data <= 8'h39)
                                || (tx_data >= 8'h41 && tx_data <= 8'h46));
  endproperty
  a_hex_digit: assert property (p_hex_digit) else $error("bad hex character");

  property p_bad_block;
    @(posedge sys_clk) disable iff (reset)
      (clk_en && state_r == rtf_pkg::S_NEXT && blk_kind && seg_r == 4'h3
       && blk_st[blk_r] == rtf_pkg::BST_BAD)
      |=> (state_r == rtf_pkg::S_LIT && lit_cnt_r == 3'h4 && lit_sr_r == 32'h58585858);
  endproperty
  a_bad_block: assert property (p_bad_block) else $error("XXXX not chosen");

  property p_ro_block;
    @(posedge sys_clk) disable iff (reset)
      (clk_en && state_r == rtf_pkg::S_NEXT && kind_r == rtf_pkg::RTF_K_WRITE
       && seg_r == 4'h3 && blk_st[blk_r] == rtf_pkg::BST_RO)
      |=> (state_r == rtf_pkg::S_LIT && lit_cnt_r == 3'h2 && lit_sr_r[31:16] == 16'h524F);
  endproperty
  a_ro_block: assert property (p_ro_block) else $error("RO not chosen");

  property p_dec_len;
    @(posedge sys_clk) disable iff (reset)
      (clk_en && state_r == rtf_pkg::S_NEXT && kind_r == rtf_pkg::RTF_K_DECODED
       && seg_r == 4'h3) |=> (state_r == rtf_pkg::S_HEX && hex_cnt_r == 6'h1C
                              && hex_sr_r[143:32] == dec_data);
  endproperty
  a_dec_len: assert property (p_dec_len) else $error("decoded length wrong");

  property p_raw_len;
    @(posedge sys_clk) disable iff (reset)
      (clk_en && state_r == rtf_pkg::S_NEXT && kind_r == rtf_pkg::RTF_K_RAW
       && seg_r == 4'h3) |=> (hex_cnt_r == 6'h24 && hex_sr_r == {frame_r[142:0], 1'b0});
  endproperty
  a_raw_len: assert property (p_raw_len) else $error("raw length wrong");

endmodule

// file: testbench/rtf_host_sink.sv
`timescale 1ns/10ps
module rtf_host_sink (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset,
  // Character stream
  output logic      tx_ready
);
  logic [2:0] st_r;
  // Host stalls one cycle in eight
  always_ff @(posedge sys_clk) begin
    st_r     <= reset ? 3'h0 : st_r + 3'h1;
    tx_ready <= (st_r != 3'h3);
  end
endmodule

// file: testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic               sys_clk, reset, req_valid, req_ready, frame_err;
  logic               tx_valid, tx_ready, tx_last, blk_wr_en;
  rtf_pkg::rtf_kind_t req_kind;
  logic [152:0]       req_frame;
  logic [7:0]         tcp, tx_data;
  logic [4:0]         b_first, b_last, blk_wr_addr;
  logic [31:0]        blk_wr_data;
  logic [1:0]         blk_wr_status;
  logic [31:0]        bd [32];
  logic [1:0]         bs [32];
  logic [7:0]         q [$];
  int                 n_fail, tests_run, cyc, tk;
  localparam int      TICK = 4;

  rtf_formatter #(.TS_TICK_CYCLES(TICK)) u_rtf_formatter (.sys_clk(sys_clk), .reset(reset),
    .clk_en(1'b1), .req_valid(req_valid), .req_ready(req_ready), .req_kind(req_kind),
    .req_frame(req_frame), .req_tag_count_param(tcp), .req_blk_first(b_first),
    .req_blk_last(b_last), .frame_err(frame_err), .blk_wr_en(blk_wr_en),
    .blk_wr_addr(blk_wr_addr), .blk_wr_data(blk_wr_data), .blk_wr_status(blk_wr_status),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last));
  rtf_host_sink u_rtf_host_sink (.sys_clk(sys_clk), .reset(reset), .tx_ready(tx_ready));

  function automatic logic [7:0] hx(logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
  endfunction
  function automatic logic [31:0] rv(logic [31:0] x);
    return {<<{x}};
  endfunction
  task automatic ph(logic [143:0] v, int nn);
    for (int i = nn - 1; i >= 0; i--) q.push_back(hx(v[4*i+:4]));
  endtask
  task automatic hd(logic [7:0] c);
    q = {8'h40, c, 8'h54, 8'h00, 8'h00, 8'h00, 8'h00, 8'h2C};
  endtask
  task automatic chk(string what, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", what, e, g);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic mkframe(logic bad);
    logic [15:0] s;
    logic [7:0]  b;
    @(negedge sys_clk);
    s = 16'h0;
    req_frame = '0;
    req_frame[152:143] = 10'h3FE;
    for (int i = 0; i < 16; i++) begin
      b = (i < 14) ? ((i == 3) ? 8'hFF : 8'($urandom)) : (i == 14) ? s[15:8] ^ bad : s[7:0];
      if (i < 14) s += b;
      req_frame[142-9*i-:8] = b;
    end
  endtask

  task automatic run(rtf_pkg::rtf_kind_t k, logic bad);
    logic [7:0] s;
    logic [7:0] c;
    int         n;
    logic [15:0] ts;
    while (req_ready !== 1'b1) @(negedge sys_clk);
    req_kind = k;
    req_valid = 1'b1;
    @(negedge sys_clk);
    req_valid = 1'b0;
    // Stamp latched at the take edge, counted from reset release
    ts = 16'((tk - 1) / TICK);
    if (q[2] == 8'h54) for (int j = 0; j < 4; j++) q[3 + j] = hx(ts[15 - 4 * j -: 4]);
    if (bad) begin
      @(negedge sys_clk);
      chk("frame_err", 8'h01, {7'h0, frame_err});
      repeat (6) @(negedge sys_clk);
      chk("tx_valid", 8'h00, {7'h0, tx_valid});
      return;
    end
    s = 8'h00;
    n = q.size();
    for (int i = 0; i < n + 4; i++) begin
      do @(negedge sys_clk); while (!(tx_valid === 1'b1 && tx_ready === 1'b1));
      c = tx_data;
      chk("tx_last", {7'h0, i == n + 3}, {7'h0, tx_last});
      if (i >= 3 && i < 7 && q[2] == 8'h54) chk("stamp", q[i], c);
      else if (i < n) chk("char", q[i], c);
      else if (i == n) chk("csum hi", hx(8'(8'h00 - s) >> 4), c);
      else if (i == n + 1) chk("csum lo", hx(4'(8'h00 - s)), c);
      else chk("crlf", (i == n + 2) ? 8'h0D : 8'h0A, c);
      if (i < n) s += q[i];
    end
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (!reset) tk++;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end

  initial begin
    {reset, req_valid, req_frame, tcp, b_first, b_last} = {1'b1, 172'h0};
    {blk_wr_en, blk_wr_addr, blk_wr_data, blk_wr_status} = '0;
    req_kind = rtf_pkg::RTF_K_DECODED;
    void'($urandom(1726));
    repeat (2) @(negedge sys_clk);
    reset = 1'b0;
    for (int n = 0; n < 32; n++) begin
      @(negedge sys_clk);
      bd[n] = $urandom;
      bs[n] = (n inside {1, 3, 4, 5}) ? 2'h0 : (n < 3) ? 2'(n) : 2'($urandom % 3);
      {blk_wr_en, blk_wr_addr, blk_wr_data, blk_wr_status} = {1'b1, 5'(n), bd[n], bs[n]};
    end
    @(negedge sys_clk);
    blk_wr_en = 1'b0;
    for (int r = 0; r < 2; r++) begin
      mkframe(1'b0);
      hd(8'h32);
      for (int i = 0; i < 14; i++) ph(req_frame[142-9*i-:8], 2);
      run(rtf_pkg::RTF_K_DECODED, 1'b0);
      hd(8'h33);
      ph({req_frame[142:0], 1'b0}, 36);
      run(rtf_pkg::RTF_K_RAW, 1'b0);
      mkframe(1'b1);
      run(r ? rtf_pkg::RTF_K_RAW : rtf_pkg::RTF_K_DECODED, 1'b1);
    end
    for (int w = 0; w < 3; w++) begin
      @(negedge sys_clk);
      {b_first, b_last} = (w == 1) ? {5'h00, 5'h06} : {5'h1F, 5'h1F};
      q = {8'h40, w ? 8'h35 : 8'h34, 8'h49};
      ph(rv(bd[1]), 8);
      for (int n = w ? b_first : 0; n <= (w ? b_last : 31); n++) begin
        q = {q, 8'h2C, hx(n / 16), hx(4'(n)), 8'h3A};
        if (bs[n] == 2'h1) q = {q, 8'h58, 8'h58, 8'h58, 8'h58};
        else if (w && bs[n] == 2'h2) q = {q, 8'h52, 8'h4F};
        else ph(rv(bd[n]), 8);
      end
      run(w ? rtf_pkg::RTF_K_WRITE : rtf_pkg::RTF_K_VREAD, 1'b0);
    end
    for (int d = 0; d < 4; d++) begin
      @(negedge sys_clk);
      tcp = {3'($urandom), 2'(d), 3'($urandom)};
      hd(8'h36);
      ph(tcp, 2);
      q.push_back(8'h2C);
      ph(rv(bd[1]), 8);
      q.push_back(8'h2C);
      ph({rv(bd[3]), rv(bd[4]), rv(bd[5])} >> (96 - ((d == 3) ? 96 : 32 + 16 * d)),
        (d == 3) ? 24 : 8 + 4 * d);
      run(rtf_pkg::RTF_K_FAST, 1'b0);
    end
    results();
  end
endmodule
